// ===== rtl/vuvfm_pkg.sv
// Purpose: shared constants and carrier types for the output undervoltage monitor
// Assumes: one controller clock at 125 MHz, commands decoded upstream of this block
// Notes: thresholds are unsigned codes with one lsb worth 2^-13 volt
package vuvfm_pkg;

  // command codes of the four settings held here
  localparam logic [7:0] CMD_OV_WARN = 8'h42;
  localparam logic [7:0] CMD_UV_WARN = 8'h43;
  localparam logic [7:0] CMD_UV_FAULT = 8'h44;
  localparam logic [7:0] CMD_UV_ACTION = 8'h45;

  // linear-16 unsigned: volts = code * 2^-13, so 5.5 V is 5.5 * 8192
  localparam int LSB_EXPONENT = -13;
  localparam logic [15:0] LIMIT_MAX_CODE = 16'hb000;

  // defaults as percent of the strapped setpoint, and the action byte reset value
  localparam logic [6:0] OV_WARN_PCT = 7'd108;
  localparam logic [6:0] UV_WARN_PCT = 7'd88;
  localparam logic [6:0] UV_FAULT_PCT = 7'd85;
  localparam logic [7:0] ACTION_RESET = 8'h80;

  // action byte fields
  localparam int BEHAV_MSB = 7;
  localparam int BEHAV_LSB = 6;
  localparam logic [1:0] BEHAV_DISABLE_RETRY = 2'b10;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  // retry time unit
  localparam int CLK_MHZ = 125;
  localparam int RETRY_UNIT_MS = 35;
  localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * 1000 * CLK_MHZ;

  // strap settles through two sync stages before it is sampled
  localparam logic [1:0] INIT_CAPTURE_STAGE = 2'd3;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } vuvfm_cmd_type;

  typedef struct packed {
    logic status_word_vout;
    logic uv_fault;
    logic uv_warning;
  } vuvfm_status_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_LATCHED = 2'b01,
    ST_RETRY_WAIT = 2'b10,
    ST_TON_WAIT = 2'b11
  } vuvfm_state_type;

endpackage

// ===== rtl/vuvfm_monitor.sv
// Purpose: output undervoltage warning and fault supervision with latch-off or retry
// Assumes: vout samples, enable, power-good and ramp flags come from logic on clk
// Notes: strap value arrives from a pin and is synchronised before capture
// Notes on behaviour
// - each threshold is a 16-bit unsigned code worth code times 2^-13 volt.
// - a threshold write above 5.5 V is refused and the old value kept.
// - fault detection is masked during ramp, before power-good and while disabled.
// - a fault sets the vout summary bit and the uv fault bit and notifies the host.
// - warning defaults to 0.88 and fault to 0.85 times the strapped setpoint.
// - the action byte resets to 80h, disable with no retry and shortest delay.
// - only behaviour code 10 in bits 7:6 is used, disable then retry per bits 5:3.
// - a fault drives the alert low and sets a status bit that only clear-faults clears.
// - retry field 000 keeps the output off until the fault is cleared.
// - a nonzero retry field retries until commanded off, bias lost or another fault.
// - restart spacing is (bits 2:0 plus one) times 35 ms.
// - after each retry delay the turn-on delay still runs before the output restarts.
module vuvfm_monitor
  import vuvfm_pkg::*;
#(
  parameter int RETRY_UNIT = RETRY_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire vuvfm_cmd_type cmd,
  output logic [15:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_error,
  input wire logic clear_faults,
  input wire logic [15:0] setpoint_strap_pin,
  input wire logic meas_valid,
  input wire logic [15:0] vout_code,
  input wire logic ramp_active,
  input wire logic power_good,
  input wire logic enable_request,
  input wire logic bias_ok,
  input wire logic other_fault,
  input wire logic [31:0] ton_delay_cycles,
  output logic output_on,
  output vuvfm_status_type status,
  output logic alert_output_pin_n
);

  // percent of setpoint; product fits 24 bits for any 16-bit code
  function automatic logic [15:0] pct_of(input logic [15:0] base, input logic [6:0] pct);
    logic [23:0] prod;
    prod = base * pct;
    return 16'(prod / 24'd100);
  endfunction

  function automatic logic [31:0] retry_cycles(input logic [2:0] delay);
    return 32'((32'(delay) + 32'd1) * 32'(RETRY_UNIT));
  endfunction

  logic [15:0] strap_meta;
  logic [15:0] strap_sync;
  logic [1:0] init_stage;
  logic init_done;
  logic [15:0] ov_warn_th;
  logic [15:0] uv_warn_th;
  logic [15:0] uv_fault_th;
  logic [7:0] action;
  logic [31:0] timer;
  vuvfm_state_type state;
  logic masked;
  logic fault_event;
  logic warn_event;
  logic wr_en;
  logic th_ok;
  logic act_ok;
  logic stop_retry;
  vuvfm_status_type next_status;

  // strap pin resync; only the second stage is looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= 16'h0000;
      strap_sync <= 16'h0000;
    end else if (clk_en) begin
      strap_meta <= setpoint_strap_pin;
      strap_sync <= strap_meta;
    end
  end

  // wait until the synchroniser is full before taking defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_stage <= 2'd0;
      init_done <= 1'b0;
    end else if (clk_en && !init_done) begin
      init_stage <= init_stage + 2'd1;
      init_done <= (init_stage == INIT_CAPTURE_STAGE);
    end
  end

  // write decode and value checks
  assign wr_en = cmd.valid && cmd.write && init_done;
  assign th_ok = (cmd.wdata <= LIMIT_MAX_CODE);
  assign act_ok = (cmd.wdata[BEHAV_MSB:BEHAV_LSB] == BEHAV_DISABLE_RETRY);

  // thresholds: strap-derived defaults, then host writes within range
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_warn_th <= 16'h0000;
      uv_warn_th <= 16'h0000;
      uv_fault_th <= 16'h0000;
    end else if (clk_en) begin
      if (!init_done && init_stage == INIT_CAPTURE_STAGE) begin
        ov_warn_th <= pct_of(strap_sync, OV_WARN_PCT);
        uv_warn_th <= pct_of(strap_sync, UV_WARN_PCT);
        uv_fault_th <= pct_of(strap_sync, UV_FAULT_PCT);
      end else if (wr_en && th_ok) begin
        if (cmd.code == CMD_OV_WARN) begin
          ov_warn_th <= cmd.wdata;
        end else if (cmd.code == CMD_UV_WARN) begin
          uv_warn_th <= cmd.wdata;
        end else if (cmd.code == CMD_UV_FAULT) begin
          uv_fault_th <= cmd.wdata;
        end
      end
    end
  end

  // action byte; unused behaviour codes are refused so the field stays meaningful
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      action <= ACTION_RESET;
    end else if (clk_en && wr_en && cmd.code == CMD_UV_ACTION && act_ok) begin
      action <= cmd.wdata[7:0];
    end
  end

  // command answer one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata <= 16'h0000;
      cmd_ack <= 1'b0;
      cmd_error <= 1'b0;
    end else if (clk_en) begin
      cmd_ack <= cmd.valid && init_done;
      cmd_error <= 1'b0;
      cmd_rdata <= 16'h0000;
      if (cmd.valid && init_done) begin
        if (cmd.code == CMD_OV_WARN) begin
          cmd_rdata <= ov_warn_th;
          cmd_error <= cmd.write && !th_ok;
        end else if (cmd.code == CMD_UV_WARN) begin
          cmd_rdata <= uv_warn_th;
          cmd_error <= cmd.write && !th_ok;
        end else if (cmd.code == CMD_UV_FAULT) begin
          cmd_rdata <= uv_fault_th;
          cmd_error <= cmd.write && !th_ok;
        end else if (cmd.code == CMD_UV_ACTION) begin
          cmd_rdata <= {8'h00, action};
          cmd_error <= cmd.write && !act_ok;
        end else begin
          cmd_error <= 1'b1;
        end
      end
    end
  end

  // detection; the mask also covers retry and latch since output_on is low there
  assign masked = ramp_active || !power_good || !output_on;
  assign fault_event = meas_valid && !masked && (vout_code < uv_fault_th);
  assign warn_event = meas_valid && !masked && (vout_code < uv_warn_th);

  // sticky status: a new event in the clear cycle survives the clear
  always_comb begin
    next_status = status;
    if (clear_faults) begin
      next_status = '0;
    end
    if (fault_event) begin
      next_status.uv_fault = 1'b1;
      next_status.status_word_vout = 1'b1;
    end
    if (warn_event) begin
      next_status.uv_warning = 1'b1;
      next_status.status_word_vout = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      alert_output_pin_n <= 1'b1;
    end else if (clk_en) begin
      status <= next_status;
      alert_output_pin_n <= !(next_status.uv_fault || next_status.uv_warning);
    end
  end

  // retrying ends when the output is commanded off or bias is gone
  assign stop_retry = !enable_request || !bias_ok;

  // response sequencer; one down-counter serves retry delay and turn-on delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
      timer <= 32'h0000_0000;
    end else if (clk_en) begin
      case (state)
        ST_RUN: begin
          if (fault_event) begin
            if (action[RETRY_MSB:RETRY_LSB] == 3'b000) begin
              state <= ST_LATCHED;
            end else begin
              state <= ST_RETRY_WAIT;
              timer <= retry_cycles(action[DELAY_MSB:DELAY_LSB]);
            end
          end
        end
        ST_LATCHED: begin
          if (clear_faults) begin
            state <= ST_RUN;
          end
        end
        ST_RETRY_WAIT, ST_TON_WAIT: begin
          if (other_fault) begin
            state <= ST_LATCHED;
          end else if (stop_retry) begin
            state <= ST_RUN;
          end else if (timer > 32'h0000_0001) begin
            timer <= timer - 32'h0000_0001;
          end else if (state == ST_RETRY_WAIT) begin
            state <= ST_TON_WAIT;
            timer <= ton_delay_cycles;
          end else begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // output drive follows the sequencer, the enable request and bias
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_on <= 1'b0;
    end else if (clk_en) begin
      output_on <= (state == ST_RUN) && !fault_event && enable_request && bias_ok;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // settings port: a refused write must leave the old value, a good one must land
  a_range_reject: assert property (clk_en && wr_en
    && cmd.code == CMD_UV_FAULT && !th_ok
    |=> uv_fault_th == $past(uv_fault_th)) else $error("out-of-range threshold stored");
  a_write_store: assert property (clk_en && wr_en
    && cmd.code == CMD_UV_WARN && th_ok
    |=> uv_warn_th == $past(cmd.wdata)) else $error("threshold write lost");

  // detection and status; judged on the port values, except a_fault_status (fault_event) and a_compare_below (uv_warn_th, uv_fault_th)
  a_fault_masked: assert property (clk_en && meas_valid && !clear_faults
    && (ramp_active || !power_good || !output_on) |=> status == $past(status))
    else $error("status changed on a masked sample");
  a_fault_status: assert property (clk_en && fault_event
    |=> status.uv_fault && status.status_word_vout) else $error("fault bits not set");
  a_alert_low: assert property (status.uv_fault |-> !alert_output_pin_n)
    else $error("alert high with fault pending");
  a_sticky_hold: assert property (status.uv_fault && !clear_faults
    |=> status.uv_fault) else $error("fault bit dropped without clear");
  a_compare_below: assert property (clk_en && meas_valid && !clear_faults
    && vout_code >= uv_warn_th && vout_code >= uv_fault_th |=> status == $past(status))
    else $error("trip without sample below");

  // response sequencer
  a_latch_off: assert property (state == ST_LATCHED |=> !output_on)
    else $error("output on while latched");
  a_retry_load: assert property (clk_en && state == ST_RUN && fault_event
    && action[RETRY_MSB:RETRY_LSB] != 3'b000
    |=> state == ST_RETRY_WAIT && timer == retry_cycles($past(action[DELAY_MSB:DELAY_LSB])))
    else $error("retry delay wrong");
  a_ton_first: assert property (clk_en && state == ST_RETRY_WAIT
    && timer <= 32'h0000_0001 && !other_fault && !stop_retry
    |=> state == ST_TON_WAIT && timer == $past(ton_delay_cycles))
    else $error("turn-on delay skipped");
  a_retry_stop: assert property (clk_en && state == ST_RETRY_WAIT
    && !other_fault && stop_retry |=> state == ST_RUN && !output_on)
    else $error("retry did not stop");

  // action byte and power-up values
  a_action_code: assert property (
    action[BEHAV_MSB:BEHAV_LSB] == BEHAV_DISABLE_RETRY)
    else $error("unused behaviour code stored");
  a_action_reset: assert property (!init_done |-> action == ACTION_RESET)
    else $error("action byte not at reset value");
  a_default_take: assert property (clk_en && !init_done
    && init_stage == INIT_CAPTURE_STAGE
    |=> uv_fault_th == pct_of($past(strap_sync), UV_FAULT_PCT))
    else $error("fault default wrong");

  c_latch: cover property (state == ST_RUN ##1 state == ST_LATCHED);
  c_stop: cover property (state == ST_RETRY_WAIT ##1 state == ST_RUN && !output_on);
  c_retry: cover property (state == ST_TON_WAIT ##1 state == ST_RUN);
  c_clear: cover property (status.uv_fault ##1 clear_faults ##1 !status.uv_fault);
  c_reject: cover property (cmd_ack && cmd_error);

endmodule

// ===== test/vuvfm_host.sv
// Purpose: host model for the settings port and the clear-faults line
// Assumes: requests start at a rising edge; the answer is read once the next edge settles
// Notes: keeps the host duties on threshold order and on the latch-off choice
module vuvfm_host
  import vuvfm_pkg::*;
(
  input wire logic clk,
  output vuvfm_cmd_type cmd,
  output logic clear_faults,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rdata;
  logic err;
  logic acked;

  initial begin
    cmd = '0;
    clear_faults = 1'b0;
  end

  // one request stands one cycle; fields are scrambled after it so stale data never matches
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmd <= '{valid: 1'b1, write: wr, code: code, wdata: data};
    @(posedge clk);
    cmd <= '{valid: 1'b0, write: ~wr, code: ~code, wdata: ~data};
    // the answer stands only in the cycle after the taking edge, so read it just after that edge
    #1;
    acked = cmd_ack;
    rdata = cmd_rdata;
    err = cmd_error;
  endtask

  // the fault level is always placed below a nonzero warning level
  task automatic set_under(input logic [15:0] warn, input logic [15:0] flt);
    if (flt >= warn) flt = warn - 16'h1;
    xfer(1'b1, CMD_UV_WARN, warn);
    xfer(1'b1, CMD_UV_FAULT, flt);
  endtask

  // latch-off, so an output stuck low cannot persist unnoticed
  task automatic latch_off;
    xfer(1'b1, CMD_UV_ACTION, 16'h0080);
  endtask

  task automatic clear;
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule

// ===== test/test_vout_undervoltage_fault_monitor.sv
// Purpose: self-checking bench for the output undervoltage monitor
// Assumes: retry unit shortened to ten cycles; the host model drives the settings port
// Notes: strap, thresholds and delays are random from a fixed seed
module test_vout_undervoltage_fault_monitor
  import vuvfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int U = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic meas_valid = 1'b0, ramp_active = 1'b0, power_good = 1'b1;
  logic enable_request = 1'b1, other_fault = 1'b0;
  logic clk_en = 1'b1, bias_ok = 1'b1;
  logic [15:0] strap = 16'h2000, vout_code = 16'hffff, warn, flt, cmd_rdata;
  logic [31:0] ton = 32'h4;
  logic cmd_ack, cmd_error, clear_faults, output_on, alert_n;
  vuvfm_cmd_type cmd;
  vuvfm_status_type status;
  int mismatches = 0, comparisons = 0, n, d, t;

  always #4 clk = ~clk;

  vuvfm_monitor #(.RETRY_UNIT(U)) DUT (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cmd(cmd), .cmd_rdata(cmd_rdata),
    .cmd_ack(cmd_ack), .cmd_error(cmd_error), .clear_faults(clear_faults),
    .setpoint_strap_pin(strap), .meas_valid(meas_valid), .vout_code(vout_code),
    .ramp_active(ramp_active), .power_good(power_good), .enable_request(enable_request),
    .bias_ok(bias_ok), .other_fault(other_fault), .ton_delay_cycles(ton),
    .output_on(output_on), .status(status), .alert_output_pin_n(alert_n));

  vuvfm_host host (.clk(clk), .cmd(cmd), .clear_faults(clear_faults),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_error(cmd_error));

  function automatic logic [15:0] pct(input logic [15:0] s, input int p);
    return 16'((32'(s) * p) / 100);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one measurement; returns once the following edge has settled
  task automatic smp(input logic [15:0] v);
    @(posedge clk);
    meas_valid <= 1'b1;
    vout_code <= v;
    @(posedge clk);
    meas_valid <= 1'b0;
    vout_code <= ~v;
    @(posedge clk);
    #1;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // a hang costs far more than the whole sequence needs
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end

  initial begin
    void'($urandom(68890));
    strap = 16'h1000 + 16'($urandom % 32'h8000);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    // power-up values and an unmapped code
    host.xfer(1'b0, CMD_UV_WARN, 16'h0);
    chk(host.rdata, pct(strap, 88), "warn default");
    host.xfer(1'b0, CMD_UV_FAULT, 16'h0);
    chk(host.rdata, pct(strap, 85), "fault default");
    host.xfer(1'b0, CMD_UV_ACTION, 16'h0);
    chk(host.rdata, 16'h0080, "action default");
    host.xfer(1'b0, 8'h46, 16'h0);
    chk({host.acked, host.err, host.rdata}, {2'b11, 16'h0}, "unmapped code");
    // range limit at and just past the top code
    warn = 16'h1000 + 16'($urandom % 32'h8000);
    flt = warn - 16'h1 - 16'($urandom % 32'h0800);
    host.set_under(warn, flt);
    host.xfer(1'b1, CMD_UV_FAULT, 16'hb001);
    chk({host.err, host.rdata}, {1'b1, flt}, "over range write");
    host.xfer(1'b0, CMD_UV_FAULT, 16'h0);
    chk(host.rdata, flt, "fault kept");
    host.xfer(1'b1, CMD_OV_WARN, LIMIT_MAX_CODE);
    chk(host.err, 1'b0, "top code taken");
    // every behaviour code; only one is stored
    for (int b = 0; b < 4; b++) begin
      host.xfer(1'b1, CMD_UV_ACTION, {8'h0, 2'(b), 6'h0b});
      chk(host.err, 32'(b != 2), "behaviour code");
    end
    host.xfer(1'b0, CMD_UV_ACTION, 16'h0);
    chk(host.rdata, 16'h008b, "action kept");
    // ramp, no power-good, disabled: a zero sample must pass unseen
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      ramp_active <= (m == 0);
      power_good <= (m != 1);
      enable_request <= (m != 2);
      smp(16'h0);
      chk(status, 3'b000, "masked sample");
    end
    @(posedge clk);
    ramp_active <= 1'b0;
    power_good <= 1'b1;
    enable_request <= 1'b1;
    repeat (4) @(posedge clk);
    // a sample equal to the warning level is not below it
    smp(warn);
    chk(status, 3'b000, "sample at warning level");
    smp(flt);
    chk({status.uv_fault, status.uv_warning, alert_n}, 3'b010, "warning only");
    host.clear();
    chk({status, alert_n}, 4'b0001, "cleared");
    // latch-off stays off until cleared
    host.latch_off();
    smp(flt - 16'h1);
    chk({status, alert_n, output_on}, 5'b11100, "fault taken");
    repeat (40) @(posedge clk);
    #1;
    chk({status, output_on}, 4'b1110, "latched off");
    host.clear();
    repeat (3) @(posedge clk);
    #1;
    chk({status, output_on}, 4'b0001, "back on");
    // retry spacing plus turn-on delay, longest delay first
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 7 : $urandom % 8;
      t = 1 + $urandom % 20;
      @(posedge clk);
      ton <= 32'(t);
      host.xfer(1'b1, CMD_UV_ACTION, {8'h0, 2'b10, 3'(1 + $urandom % 7), 3'(d)});
      smp(flt - 16'h1);
      n = 0;
      while (output_on !== 1'b1 && n < 400) begin
        @(posedge clk);
        #1;
        n++;
      end
      // counted from the edge after the fault sample; output rises one edge after the run state
      chk(n, (d + 1) * U + t, "restart spacing");
      host.clear();
    end
    // bias lost mid-wait ends retrying; the output then follows bias, not the retry timer
    smp(flt - 16'h1);
    @(posedge clk);
    bias_ok <= 1'b0;
    @(posedge clk);
    bias_ok <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(output_on, 1'b1, "retry ended by bias loss");
    host.clear();
    // another fault during the wait ends the retries
    smp(flt - 16'h1);
    @(posedge clk);
    other_fault <= 1'b1;
    @(posedge clk);
    other_fault <= 1'b0;
    repeat (8 * U + 40) @(posedge clk);
    #1;
    chk(output_on, 1'b0, "retries stopped");
    // with clk_en low a clear pulse is not seen, so the fault stays latched
    @(posedge clk);
    clk_en <= 1'b0;
    host.clear();
    chk({status, output_on}, 4'b1110, "frozen while clock enable low");
    @(posedge clk);
    clk_en <= 1'b1;
    host.clear();
    repeat (3) @(posedge clk);
    #1;
    chk({status, output_on}, 4'b0001, "cleared after freeze");
    finish_test();
  end
endmodule
